// File: rrs_pkg.sv
// Shared types and constants for the rotate-right / subtract-with-borrow datapath.
// Assumes one core clock; requests come from decoder logic on that clock.
package rrs_pkg;

    // Datapath width and bit positions
    localparam int          DATA_W      = 8;
    localparam int          MSB_POS     = 7;
    localparam int          LSB_POS     = 0;
    localparam int          NIB_W       = 4;

    // Values after reset
    localparam logic [7:0]  WORKING_RST = 8'h00;
    localparam logic        FLAG_RST    = 1'b0;

    // Operation codes from the decoder
    typedef enum logic [2:0] {
        OP_ROTATE_RIGHT_IN_PLACE            = 3'h0,
        OP_ROTATE_RIGHT_TO_WORKING          = 3'h1,
        OP_ROTATE_RIGHT_THROUGH_BORROW_BIT  = 3'h2,
        OP_ROTATE_RIGHT_BORROW_BIT_TO_WORK  = 3'h3,
        OP_SUBTRACT_WITH_BORROW_MEM         = 3'h4,
        OP_SUBTRACT_WITH_BORROW_IMM         = 3'h5,
        OP_LOAD_WORKING                     = 3'h6,
        OP_LOAD_CARRY                       = 3'h7
    } rrs_op_type;

    // One request per instruction cycle
    typedef struct packed {
        logic            valid;     // Request present this cycle
        rrs_op_type      op;        // Which operation
        logic [7:0]      mem_data;  // Byte read from data memory
        logic [7:0]      imm;       // Literal byte from the instruction
    } rrs_req_type;

    // Status flags held by the block
    typedef struct packed {
        logic carry;               // Carry / not-borrow
        logic signed_range_flag;   // Signed overflow
        logic zero;                // Result is zero
        logic nibble_borrow_flag;  // Set when low nibble did not borrow
        logic extra_signed_flag;   // True sign of the result
        logic extra_null_flag;     // Zero chained across multi-byte subtracts
    } rrs_flags_type;

    // Combinational outcome of one operation
    typedef struct packed {
        logic [7:0]      value;     // Result byte
        rrs_flags_type   flags;     // Flags after the operation
        logic            to_mem;    // Result goes back to memory
        logic            to_work;   // Result goes to the working register
    } rrs_res_type;

endpackage

// File: rrs_alu.sv
// Combinational core: rotate and subtract-with-borrow arithmetic.
// Assumes the caller registers the result and flags in one edge.
`timescale 1ns/10ps
`default_nettype none
module rrs_alu (
    input  wire rrs_pkg::rrs_req_type   req,
    input  wire logic [7:0]             working,
    input  wire rrs_pkg::rrs_flags_type flags_in,
    output rrs_pkg::rrs_res_type        res
);

    // Shared subtract path; operand picks memory or literal
    logic [7:0] operand;
    logic [8:0] diff;
    logic [4:0] low_diff;
    logic       ov;

    always_comb begin
        res      = '0;
        res.flags = flags_in;
        // Memory operand unless the literal form was decoded
        operand  = (req.op == rrs_pkg::OP_SUBTRACT_WITH_BORROW_IMM) ? req.imm : req.mem_data;
        // Nine-bit difference; bit 8 set means a true borrow out
        diff     = {1'b0, working} - {1'b0, operand} - {8'h00, ~flags_in.carry};
        // Low nibble on its own for the half-borrow flag
        low_diff = {1'b0, working[3:0]} - {1'b0, operand[3:0]} - {4'h0, ~flags_in.carry};
        // Signs of operands differ and result sign left the minuend's
        ov       = (working[7] != operand[7]) && (diff[7] != working[7]);
        unique case (req.op)
            rrs_pkg::OP_ROTATE_RIGHT_IN_PLACE: begin
                res.value  = {req.mem_data[0], req.mem_data[7:1]};
                res.to_mem = 1'b1;
            end
            rrs_pkg::OP_ROTATE_RIGHT_TO_WORKING: begin
                res.value   = {req.mem_data[0], req.mem_data[7:1]};
                res.to_work = 1'b1;
            end
            rrs_pkg::OP_ROTATE_RIGHT_THROUGH_BORROW_BIT: begin
                res.value       = {flags_in.carry, req.mem_data[7:1]};
                res.flags.carry = req.mem_data[0];
                res.to_mem      = 1'b1;
            end
            rrs_pkg::OP_ROTATE_RIGHT_BORROW_BIT_TO_WORK: begin
                res.value       = {flags_in.carry, req.mem_data[7:1]};
                res.flags.carry = req.mem_data[0];
                res.to_work     = 1'b1;
            end
            rrs_pkg::OP_SUBTRACT_WITH_BORROW_MEM,
            rrs_pkg::OP_SUBTRACT_WITH_BORROW_IMM: begin
                res.value                    = diff[7:0];
                res.to_work                  = 1'b1;
                res.flags.carry              = ~diff[8];
                res.flags.signed_range_flag  = ov;
                res.flags.zero               = (diff[7:0] == 8'h00);
                res.flags.nibble_borrow_flag = ~low_diff[4];
                res.flags.extra_signed_flag  = ov ^ diff[7];
                res.flags.extra_null_flag    = (diff[7:0] == 8'h00) && flags_in.extra_null_flag;
            end
            rrs_pkg::OP_LOAD_WORKING: begin
                res.value   = req.imm;
                res.to_work = 1'b1;
            end
            rrs_pkg::OP_LOAD_CARRY: begin
                res.value       = working;
                res.flags.carry = req.imm[0];
                // Seeds the chained-zero flag; without it the chain could never start
                res.flags.extra_null_flag = req.imm[1];
            end
        endcase
    end

endmodule
`default_nettype wire

// File: rrs_core.sv
// Top of the rotate-right / subtract-with-borrow datapath slice.
// Holds the working register and flags; writes memory through a strobe.
// Assumes the decoder presents one request per cycle on core_clk.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - In-place rotate right, bit 0 to 7
// - Rotate right copy, low bit to top
// - Copy goes to working, memory untouched
// - Rotate through carry in place, carry updated
// - Rotate through carry into working register
// - Working minus memory minus inverted carry
// - Carry clear on negative, set otherwise
// - Immediate subtract with borrow, same flags
module rrs_core (
    input  wire logic                   core_clk,
    input  wire logic                   rstn,
    input  wire rrs_pkg::rrs_req_type   req,
    output logic [7:0]                  working_register,
    output rrs_pkg::rrs_flags_type      flags,
    output logic                        mem_wr_en,
    output logic [7:0]                  mem_wr_data,
    output logic                        done
);

    // State and its next values
    logic [7:0]             working_reg;      // Working register
    rrs_pkg::rrs_flags_type flags_reg;        // Status flags
    logic                   mem_wr_en_reg;    // One-cycle memory write strobe
    logic [7:0]             mem_wr_data_reg;  // Byte to write back
    logic                   done_reg;         // Request retired pulse
    rrs_pkg::rrs_res_type   res_next;         // Arithmetic outcome

    // Arithmetic lives in its own module so the top stays register-only
    rrs_alu u_alu (
        .req      (req),
        .working  (working_reg),
        .flags_in (flags_reg),
        .res      (res_next)
    );

    // Working register; only written on a retired request
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            working_reg <= rrs_pkg::WORKING_RST;
        end else if (req.valid && res_next.to_work) begin
            working_reg <= res_next.value;
        end
    end

    // Flags latch on the same edge as the destination write
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            flags_reg <= '{default: rrs_pkg::FLAG_RST};
        end else if (req.valid) begin
            flags_reg <= res_next.flags;
        end
    end

    // Memory write-back strobe; lasts exactly one cycle per in-place rotate request
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mem_wr_en_reg   <= 1'b0;
            mem_wr_data_reg <= 8'h00;
        end else begin
            mem_wr_en_reg <= req.valid && res_next.to_mem;
            if (req.valid && res_next.to_mem) begin
                mem_wr_data_reg <= res_next.value;
            end
        end
    end

    // Completion pulse; no stall path exists, so every request retires
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= req.valid;
        end
    end

    // Outputs straight from flops
    assign working_register = working_reg;
    assign flags            = flags_reg;
    assign mem_wr_en        = mem_wr_en_reg;
    assign mem_wr_data      = mem_wr_data_reg;
    assign done             = done_reg;

    // Checking helpers: request fields as plain signals
    logic       chk_valid;
    logic [7:0] chk_mem;
    logic [7:0] chk_imm;
    logic [2:0] chk_op;
    logic [8:0] chk_diff;
    assign chk_valid = req.valid;
    assign chk_mem   = req.mem_data;
    assign chk_imm   = req.imm;
    assign chk_op    = req.op;
    // Reference subtraction for the immediate and memory forms
    assign chk_diff  = {1'b0, working_reg}
                     - {1'b0, (chk_op == 3'h5) ? chk_imm : chk_mem}
                     - {8'h00, ~flags_reg.carry};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // In-place rotate writes rotated byte, flags and working hold
    property p_rot_in_place;
        chk_valid && chk_op == 3'h0 |=> mem_wr_en && mem_wr_data == {$past(chk_mem[0]),
            $past(chk_mem[7:1])} && $stable(flags) && $stable(working_register);
    endproperty
    a_rot_in_place: assert property (p_rot_in_place) else $error("in-place rotate wrong");

    // Rotate to working gives rotated byte in working register
    property p_rot_to_work;
        chk_valid && chk_op == 3'h1 |=> working_register == {$past(chk_mem[0]),
            $past(chk_mem[7:1])};
    endproperty
    a_rot_to_work: assert property (p_rot_to_work) else $error("rotate to working wrong");

    // Rotate to working leaves memory and flags alone
    property p_rot_to_work_quiet;
        chk_valid && chk_op == 3'h1 |=> !mem_wr_en && $stable(flags);
    endproperty
    a_rot_to_work_quiet: assert property (p_rot_to_work_quiet) else $error("rotate copy side effect");

    // Rotate through carry in place: bit 0 to carry, old carry to bit 7
    property p_rrc_mem;
        logic c;
        (chk_valid && chk_op == 3'h2, c = flags.carry) |=> mem_wr_en
            && mem_wr_data == {c, $past(chk_mem[7:1])} && flags.carry == $past(chk_mem[0]);
    endproperty
    a_rrc_mem: assert property (p_rrc_mem) else $error("rotate through carry wrong");

    // Rotate through carry to working, no memory write
    property p_rrc_work;
        logic c;
        (chk_valid && chk_op == 3'h3, c = flags.carry) |=> !mem_wr_en
            && working_register == {c, $past(chk_mem[7:1])} && flags.carry == $past(chk_mem[0]);
    endproperty
    a_rrc_work: assert property (p_rrc_work) else $error("rotate carry copy wrong");

    // Memory subtract result and zero flag
    property p_sbc_mem;
        chk_valid && chk_op == 3'h4 |=> working_register == $past(chk_diff[7:0])
            && flags.zero == ($past(chk_diff[7:0]) == 8'h00) && !mem_wr_en;
    endproperty
    a_sbc_mem: assert property (p_sbc_mem) else $error("memory subtract wrong");

    // Carry is the inverse of the true borrow
    property p_sbc_carry;
        chk_valid && (chk_op == 3'h4 || chk_op == 3'h5) |=> flags.carry == !$past(chk_diff[8]);
    endproperty
    a_sbc_carry: assert property (p_sbc_carry) else $error("subtract carry wrong");

    // Immediate subtract result
    property p_sbc_imm;
        chk_valid && chk_op == 3'h5 |=> working_register == $past(chk_diff[7:0]);
    endproperty
    a_sbc_imm: assert property (p_sbc_imm) else $error("immediate subtract wrong");

    // Chained zero flag survives only a run of zero results
    property p_sbc_null_chain;
        chk_valid && (chk_op == 3'h4 || chk_op == 3'h5) |=> flags.extra_null_flag ==
            (($past(chk_diff[7:0]) == 8'h00) && $past(flags.extra_null_flag));
    endproperty
    a_sbc_null_chain: assert property (p_sbc_null_chain) else $error("chained zero wrong");

    // Flags never move without a request
    property p_flags_hold;
        !chk_valid |=> $stable(flags) && $stable(working_register) && !mem_wr_en;
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("state moved when idle");

    // Back-to-back requests each retire the next cycle
    property p_one_cycle;
        chk_valid ##1 chk_valid |=> done ##0 $past(done);
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("request did not retire");

    // Main scenarios
    c_rot_in_place: cover property (chk_valid && chk_op == 3'h0 ##1 mem_wr_en);
    c_sbc_negative: cover property (chk_valid && chk_op == 3'h4 ##1 !flags.carry);
    c_sbc_zero:     cover property (chk_valid && chk_op == 3'h5 ##1 flags.zero);
    c_rrc_chain:    cover property (chk_valid && chk_op == 3'h2 ##1 chk_valid && chk_op == 3'h3);
    c_null_chain:   cover property (chk_valid && chk_op == 3'h5 ##1 flags.extra_null_flag);

endmodule
`default_nettype wire

// File: rrs_core_tb.sv
// Self-checking bench for the rotate-right / subtract-with-borrow slice.
// Assumes rrs_pkg and rrs_core are compiled first; the bench drives req itself.
`timescale 1ns/10ps
`default_nettype none
module rrs_core_tb;
    logic                   core_clk = 1'b0;  // 250 MHz core clock
    logic                   rstn     = 1'b0;  // Held low at start
    rrs_pkg::rrs_req_type   req      = '0;    // Request into the slice
    logic [7:0]             working_register;
    rrs_pkg::rrs_flags_type flags;
    logic                   mem_wr_en;
    logic [7:0]             mem_wr_data;
    logic                   done;
    int                     miscompares = 0;  // Mismatch count
    int                     compares    = 0;  // Comparison count
    int                     seed        = 50550;
    // Model state, updated in request order
    logic [7:0]             m_work  = 8'h00;
    rrs_pkg::rrs_flags_type m_flags = '0;
    logic [7:0]             m_wdata = 8'h00;

    // Free-running clock, 4 ns period
    always #2 core_clk = ~core_clk;

    rrs_core DUT (
        .core_clk         (core_clk),
        .rstn             (rstn),
        .req              (req),
        .working_register (working_register),
        .flags            (flags),
        .mem_wr_en        (mem_wr_en),
        .mem_wr_data      (mem_wr_data),
        .done             (done)
    );

    // One comparison; case inequality so unknowns never match
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Compare every output with the model
    task automatic check_all(input logic wen, input logic dn);
        check(working_register, m_work);
        check({2'h0, flags}, {2'h0, m_flags});
        check({7'h0, mem_wr_en}, {7'h0, wen});
        check(mem_wr_data, m_wdata);
        check({7'h0, done}, {7'h0, dn});
    endtask

    // Present one request at the falling edge, check one cycle later
    task automatic do_op(input logic v, input rrs_pkg::rrs_op_type op,
                         input logic [7:0] md, input logic [7:0] im);
        int         b;
        int         d;
        logic [7:0] sb;
        logic [7:0] r;
        logic       ov;
        logic       wen;
        req.valid = v;
        req.op    = op;
        req.mem_data = md;
        req.imm   = im;
        wen = 1'b0;
        if (v) begin
            case (op)
                rrs_pkg::OP_ROTATE_RIGHT_IN_PLACE: begin
                    wen = 1'b1;
                    m_wdata = {md[0], md[7:1]};
                end
                rrs_pkg::OP_ROTATE_RIGHT_TO_WORKING: begin
                    m_work = {md[0], md[7:1]};
                end
                rrs_pkg::OP_ROTATE_RIGHT_THROUGH_BORROW_BIT: begin
                    wen = 1'b1;
                    m_wdata = {m_flags.carry, md[7:1]};
                    m_flags.carry = md[0];
                end
                rrs_pkg::OP_ROTATE_RIGHT_BORROW_BIT_TO_WORK: begin
                    m_work = {m_flags.carry, md[7:1]};
                    m_flags.carry = md[0];
                end
                rrs_pkg::OP_SUBTRACT_WITH_BORROW_MEM, rrs_pkg::OP_SUBTRACT_WITH_BORROW_IMM: begin
                    // Borrow in is the inverted carry
                    sb = (op == rrs_pkg::OP_SUBTRACT_WITH_BORROW_MEM) ? md : im;
                    b  = m_flags.carry ? 0 : 1;
                    d  = int'(m_work) - int'(sb) - b;
                    r  = d[7:0];
                    ov = (m_work[7] != sb[7]) && (r[7] != m_work[7]);
                    m_flags.carry = (d >= 0);
                    m_flags.nibble_borrow_flag = (int'(m_work[3:0]) - int'(sb[3:0]) - b) >= 0;
                    m_flags.zero = (r == 8'h00);
                    m_flags.signed_range_flag = ov;
                    m_flags.extra_signed_flag = ov ^ r[7];
                    m_flags.extra_null_flag = (r == 8'h00) && m_flags.extra_null_flag;
                    m_work = r;
                end
                rrs_pkg::OP_LOAD_WORKING: begin
                    m_work = im;
                end
                default: begin
                    m_flags.carry = im[0];
                    m_flags.extra_null_flag = im[1];
                end
            endcase
        end
        @(negedge core_clk);
        check_all(wen, v);
    endtask

    // Main sequence: reset, directed edges, random mix, second reset
    initial begin
        repeat (20) @(negedge core_clk);
        check_all(1'b0, 1'b0);
        rstn = 1'b1;
        $display("test reset done");
        // Borrow through zero, then signed overflow, then back to back rotates
        do_op(1'b1, rrs_pkg::OP_SUBTRACT_WITH_BORROW_IMM, 8'h00, 8'hFF);
        do_op(1'b1, rrs_pkg::OP_LOAD_WORKING, 8'h00, 8'h7F);
        do_op(1'b1, rrs_pkg::OP_LOAD_CARRY, 8'h00, 8'h01);
        do_op(1'b1, rrs_pkg::OP_SUBTRACT_WITH_BORROW_MEM, 8'h80, 8'h00);
        do_op(1'b1, rrs_pkg::OP_ROTATE_RIGHT_THROUGH_BORROW_BIT, 8'h01, 8'h00);
        do_op(1'b1, rrs_pkg::OP_ROTATE_RIGHT_IN_PLACE, 8'h01, 8'h00);
        // Seeded chain with a zero result keeps the chained-zero flag set
        do_op(1'b1, rrs_pkg::OP_LOAD_CARRY, 8'h00, 8'h03);
        do_op(1'b1, rrs_pkg::OP_LOAD_WORKING, 8'h00, 8'h05);
        do_op(1'b1, rrs_pkg::OP_SUBTRACT_WITH_BORROW_IMM, 8'h00, 8'h05);
        $display("test directed done");
        // Random operations, roughly one idle cycle in four
        for (int i = 0; i < 3000; i++) begin
            do_op(($random(seed) & 3) != 0, rrs_pkg::rrs_op_type'($random(seed) & 7),
                  8'($random(seed)), 8'($random(seed)));
        end
        $display("test random done");
        // Reset in mid-run returns everything to zero
        rstn = 1'b0;
        req  = '0;
        m_work  = 8'h00;
        m_flags = '0;
        m_wdata = 8'h00;
        repeat (2) @(negedge core_clk);
        check_all(1'b0, 1'b0);
        rstn = 1'b1;
        do_op(1'b1, rrs_pkg::OP_ROTATE_RIGHT_BORROW_BIT_TO_WORK, 8'hA5, 8'h00);
        $display("test second reset done");
        summarize();
    end
endmodule
`default_nettype wire
